// File: common/i2cs_pkg.sv
package i2cs_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADR_DATA  = 3'h0;
    localparam logic [2:0] ADR_OWN   = 3'h1;
    localparam logic [2:0] ADR_CTRL0 = 3'h2;
    localparam logic [2:0] ADR_CTRL1 = 3'h3;
    localparam logic [2:0] ADR_TOC   = 3'h4;
    // Reset values
    localparam logic [7:0] RST_DATA  = 8'h00;
    localparam logic [6:0] RST_OWN   = 7'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h01;
    localparam logic [7:0] RST_TOC   = 8'h00;
    // First control register fields
    localparam int CTRL0_EN   = 7;
    // Second control register fields
    localparam int CTRL1_MTCH = 6;
    localparam int CTRL1_BUSY = 5;
    localparam int CTRL1_TXS  = 4;
    localparam int CTRL1_TXAK = 3;
    localparam int CTRL1_SRW  = 2;
    localparam int CTRL1_RXAK = 0;
    // Timeout control fields
    localparam int TOC_EN   = 7;
    localparam int TOC_FLAG = 6;
    localparam int TOC_SELW = 6;
    // Timing
    localparam int MCLK_HZ     = 40000000;
    localparam int SUB_CLK_HZ  = 32000;
    localparam int SUB_DIV     = 32;
    localparam int TICK_CYC    = (MCLK_HZ / SUB_CLK_HZ) * SUB_DIV;
    localparam int BYTE_BITS   = 8;
    // Slave bus states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT_STOP
    } slv_state_t;
endpackage

// File: common/tmo_if.sv
`timescale 1ns/10ps
// Links the bus engine to the timeout watchdog
interface tmo_if;
    logic       arm;       // Address match after START
    logic       scl_fall;  // Synchronised SCL falling edge
    logic       halt;      // STOP seen on the bus
    logic       enable;    // Timeout enable bit
    logic [5:0] period;    // Period select field
    logic       expire;    // One-cycle overflow pulse
    modport ctrl (output arm, scl_fall, halt, enable, period, input expire);
    modport cnt  (input arm, scl_fall, halt, enable, period, output expire);
endinterface

// File: core/i2cs_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser, one chain per bit
module i2cs_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    // Async in, synced out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;  // First stage, read only by second

    // Idle bus is high, so reset both stages high
    for (genvar b = 0; b < W; b++) begin : g_bit
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                meta[b]   <= 1'b1;
                o_sync[b] <= 1'b1;
            end else begin
                meta[b]   <= i_async[b];
                o_sync[b] <= meta[b];
            end
        end
    end
endmodule

// File: core/i2cs_timeout.sv
`timescale 1ns/10ps
// Bus timeout watchdog clocked from a sub-clock tick
module i2cs_timeout
    import i2cs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    // Engine link
    tmo_if.cnt        tif
);
    logic [15:0] pre;   // Sub-clock divider
    logic        tick;  // One pulse per sub/32 period
    logic        run;   // Watchdog counting
    logic [6:0]  cnt;   // Elapsed ticks since last SCL fall
    logic        over;  // Overflow this cycle

    // Tick stands in for the sub clock, so no crossing is needed
    assign tick = (pre == 16'(TICK_CYCLES - 1));
    assign over = run && tick && (cnt == {1'b0, tif.period});

    // Divider never stops, like the always-on oscillator
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || tick) begin
            pre <= 16'h0000;
        end else begin
            pre <= pre + 16'h0001;
        end
    end

    // Run control
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            run <= 1'b0;
        end else if (tif.halt || over || !tif.enable) begin
            run <= 1'b0;
        end else if (tif.arm) begin
            run <= 1'b1;
        end
    end

    // Elapsed count, cleared by every SCL falling edge
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || tif.arm || tif.scl_fall || !run) begin
            cnt <= 7'h00;
        end else if (tick) begin
            cnt <= cnt + 7'h01;
        end
    end

    // Overflow pulse
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tif.expire <= 1'b0;
        end else begin
            tif.expire <= over;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_tmo_clear: assert property (tif.scl_fall |=> cnt == 7'h00)
        else $error("timeout count not cleared by SCL fall");
    a_tmo_halt: assert property (tif.halt |=> !run ##1 !tif.expire)
        else $error("timeout still running after STOP");
endmodule

// File: core/i2cs_top.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
// I2C slave byte engine with bus timeout watchdog
module i2cs_top
    import i2cs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    // Register port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // I2C bus pins, open drain
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_scl_out,
    output logic            o_scl_oe,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Interrupt request
    output logic            o_irq
);
    slv_state_t state;       // Bus engine state
    logic [1:0] pins_s;      // Synchronised SCL, SDA
    logic       scl_s;       // Synced SCL
    logic       sda_s;       // Synced SDA
    logic       scl_q;       // SCL one cycle late
    logic       sda_q;       // SDA one cycle late
    logic       scl_rise;    // Sample edge
    logic       scl_fall;    // Drive edge
    logic       bus_start;   // START condition
    logic       bus_stop;    // STOP condition
    logic [7:0] sh;          // Shift register
    logic [3:0] bitcnt;      // Bits moved in this byte
    // Registers
    logic [7:0] data_buf;    // serial_data_buffer
    logic [6:0] own_addr;    // own_address_reg bits 7..1
    logic       ctrl0_en;    // Engine enable
    logic       match_flag;  // addr_match_flag
    logic       busy;        // Bus busy between START and STOP
    logic       tx_sel;      // transmit_select
    logic       sent_ack;    // sent_ack_bit, 0 acknowledges
    logic       rd_dir;      // master_read_dir_flag
    logic       rx_ack;      // received_ack_flag, 1 is no ack
    logic       toc_en;      // timeout_enable
    logic       toc_flag;    // timeout_flag
    logic [5:0] toc_sel;     // timeout_period_sel
    // Events
    logic       addr_hit;    // Own address seen
    logic       rx_done;     // Data byte received
    logic       tx_done;     // Ack slot of sent byte ends
    logic       sw_release;  // Software serviced the buffer
    logic       wr_data;     // Write to data buffer
    logic       rd_data;     // Read of data buffer
    logic       tmo;         // Watchdog overflow pulse

    tmo_if tif ();

    // Pin synchronisers
    i2cs_sync #(.W(2)) u_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_scl, i_sda}),
        .o_sync    (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Watchdog
    i2cs_timeout #(.TICK_CYCLES(TICK_CYCLES)) u_tmo (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .tif       (tif)
    );
    assign tif.arm      = addr_hit;
    assign tif.scl_fall = scl_fall;
    assign tif.halt     = bus_stop;
    assign tif.enable   = toc_en;
    assign tif.period   = toc_sel;
    assign tmo          = tif.expire;

    // Previous pin levels for edge and condition detection
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop  = scl_s && scl_q && !sda_q && sda_s;

    // Event decode
    assign wr_data    = i_wr && (i_addr == ADR_DATA);
    assign rd_data    = i_rd && (i_addr == ADR_DATA);
    assign addr_hit   = (state == ST_ADDR) && scl_fall && (bitcnt == 4'(BYTE_BITS))
                        && (sh[7:1] == own_addr);
    assign rx_done    = (state == ST_RX) && scl_fall && (bitcnt == 4'(BYTE_BITS));
    assign tx_done    = (state == ST_TX_ACK) && scl_fall;
    // Transmit waits for a write, receive for a dummy read
    assign sw_release = (state == ST_HOLD) && ((tx_sel && wr_data) || (!tx_sel && rd_data));

    // Bus engine
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || tmo || !ctrl0_en) begin
            // Timeout drops the engine back to idle and frees both lines
            state    <= ST_IDLE;
            sh       <= 8'h00;
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (bus_stop) begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else if (bus_start) begin
            // Repeated START restarts address capture
            state    <= ST_ADDR;
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh     <= {sh[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'(BYTE_BITS)) begin
                        if (addr_hit) begin
                            o_sda_oe <= 1'b1;
                            state    <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_WAIT_STOP;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        // Release ack, stretch SCL until serviced
                        o_sda_oe <= 1'b0;
                        o_scl_oe <= 1'b1;
                        state    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (sw_release) begin
                        o_scl_oe <= 1'b0;
                        bitcnt   <= 4'h0;
                        if (tx_sel) begin
                            // SCL is low, so the MSB goes out at once
                            sh       <= i_wdata;
                            o_sda_oe <= !i_wdata[7];
                            state    <= ST_TX;
                        end else begin
                            state <= ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh     <= {sh[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (rx_done) begin
                        o_sda_oe <= !sent_ack;
                        state    <= ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        o_scl_oe <= 1'b1;
                        state    <= ST_HOLD;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'(BYTE_BITS - 1)) begin
                            // Let the master drive its ack
                            o_sda_oe <= 1'b0;
                            state    <= ST_TX_ACK;
                        end else begin
                            o_sda_oe <= !sh[6];
                            sh       <= {sh[6:0], 1'b0};
                            bitcnt   <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (tx_done) begin
                        if (!rx_ack) begin
                            o_scl_oe <= 1'b1;
                            state    <= ST_HOLD;
                        end else begin
                            o_sda_oe <= 1'b0;
                            state    <= ST_WAIT_STOP;
                        end
                    end
                end
                ST_IDLE, ST_WAIT_STOP: begin
                    // Lines released, waiting for START or STOP
                    o_sda_oe <= 1'b0;
                    o_scl_oe <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Open drain pins only ever pull low
    always_ff @(posedge i_mclk) begin
        o_scl_out <= 1'b0;
        o_sda_out <= 1'b0;
    end

    // Data buffer: bus receive wins over a same-cycle software write
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            data_buf <= RST_DATA;
        end else if (rx_done) begin
            // Shift register already holds the whole byte, MSB in bit 7
            data_buf <= sh;
        end else if (wr_data) begin
            data_buf <= i_wdata;
        end
    end

    // Own address and first control register, untouched by timeout
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            own_addr <= RST_OWN;
            ctrl0_en <= 1'b0;
        end else if (i_wr && i_addr == ADR_OWN) begin
            own_addr <= i_wdata[7:1];
        end else if (i_wr && i_addr == ADR_CTRL0) begin
            ctrl0_en <= i_wdata[CTRL0_EN];
        end
    end

    // Second control register; hardware events beat software writes
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || tmo) begin
            match_flag <= RST_CTRL1[CTRL1_MTCH];
            busy       <= RST_CTRL1[CTRL1_BUSY];
            tx_sel     <= RST_CTRL1[CTRL1_TXS];
            sent_ack   <= RST_CTRL1[CTRL1_TXAK];
            rd_dir     <= RST_CTRL1[CTRL1_SRW];
            rx_ack     <= RST_CTRL1[CTRL1_RXAK];
        end else begin
            if (i_wr && i_addr == ADR_CTRL1) begin
                tx_sel   <= i_wdata[CTRL1_TXS];
                sent_ack <= i_wdata[CTRL1_TXAK];
            end
            if (bus_start) begin
                busy <= 1'b1;
            end else if (bus_stop) begin
                busy <= 1'b0;
            end
            if (addr_hit) begin
                match_flag <= 1'b1;
                rd_dir     <= sh[0];
                tx_sel     <= sh[0];
            end else if (sw_release) begin
                match_flag <= 1'b0;
            end
            if (state == ST_TX_ACK && scl_rise) begin
                rx_ack <= sda_s;
            end
        end
    end

    // Timeout control; the overflow set beats a software clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            toc_en   <= RST_TOC[TOC_EN];
            toc_flag <= RST_TOC[TOC_FLAG];
            toc_sel  <= RST_TOC[TOC_SELW-1:0];
        end else if (tmo) begin
            toc_en   <= 1'b0;
            toc_flag <= 1'b1;
        end else if (i_wr && i_addr == ADR_TOC) begin
            toc_en   <= i_wdata[TOC_EN];
            toc_flag <= toc_flag & i_wdata[TOC_FLAG];
            toc_sel  <= i_wdata[TOC_SELW-1:0];
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !i_rd) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_addr)
                ADR_DATA:  o_rdata <= data_buf;
                ADR_OWN:   o_rdata <= {own_addr, 1'b0};
                ADR_CTRL0: o_rdata <= {ctrl0_en, 7'h00};
                ADR_CTRL1: o_rdata <= {1'b0, match_flag, busy, tx_sel, sent_ack, rd_dir, 1'b0, rx_ack};
                ADR_TOC:   o_rdata <= {toc_en, toc_flag, toc_sel};
                default:   o_rdata <= 8'h00;
            endcase
        end
    end

    // One interrupt line shared by match, byte done and timeout
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= addr_hit || rx_done || tx_done || tmo;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_hit;
        addr_hit && !tmo && ctrl0_en;
    endsequence
    sequence s_acked;
        o_sda_oe && match_flag && o_irq;
    endsequence
    sequence s_stalled;
        state == ST_HOLD && !sw_release && !tmo && !bus_stop && !bus_start && ctrl0_en;
    endsequence

    a_addr_ack: assert property (s_hit |=> s_acked)
        else $error("address match not acknowledged");
    a_dir_select: assert property (s_hit |=> tx_sel == $past(sh[0]) && rd_dir == tx_sel)
        else $error("transmit select does not follow direction bit");
    a_rx_ack_low: assert property (rx_done && !sent_ack && !tmo && !bus_stop && ctrl0_en |=> o_sda_oe)
        else $error("received byte not acknowledged");
    a_nack_release: assert property (tx_done && rx_ack && !tmo && !bus_stop && ctrl0_en
                                     |=> !o_sda_oe && state == ST_WAIT_STOP)
        else $error("SDA not released after no acknowledge");
    a_rx_store: assert property (rx_done |=> data_buf == $past(sh))
        else $error("received byte not stored");
    a_scl_hold: assert property (s_stalled ##1 s_stalled |-> o_scl_oe)
        else $error("SCL not held while buffer unserviced");
    a_tmo_flag: assert property (tmo |=> toc_flag && !toc_en && o_irq)
        else $error("timeout did not set flag and interrupt");
    a_tmo_ctrl1: assert property (tmo |=> !match_flag && !tx_sel && rx_ack && state == ST_IDLE)
        else $error("timeout did not reset second control");
endmodule

// File: verif/i2c_master_model.sv
`timescale 1ns/10ps
// Bus master model, open drain, slow bit rate
module i2c_master_model (
    // Clock and wire levels
    input  wire logic i_mclk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Pull-low drives
    output logic      o_scl_low,
    output logic      o_sda_low
);
    // Both lines released at power-up
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // Half bit of ten clocks
    task automatic tick();
        repeat (10) @(posedge i_mclk);
    endtask
    // Release SCL and wait out a stretch, bounded so a stuck slave cannot hang us
    task automatic rise();
        int n;
        n = 0;
        o_scl_low <= 1'b0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (!i_scl && n < 4000);
        tick();
    endtask
    // Start or repeated start
    task automatic start();
        o_sda_low <= 1'b0;
        tick();
        rise();
        o_sda_low <= 1'b1;
        tick();
        o_scl_low <= 1'b1;
        tick();
    endtask
    // Stop, also used after a missing acknowledge
    task automatic stop();
        o_sda_low <= 1'b1;
        tick();
        rise();
        o_sda_low <= 1'b0;
        tick();
    endtask
    // Eight bits MSB first, then the ack slot; a 1 releases SDA
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
        logic [8:0] s;
        s = {d, a};
        for (int i = 8; i >= 0; i--) begin
            o_sda_low <= ~s[i];
            tick();
            rise();
            s[i] = i_sda;
            o_scl_low <= 1'b1;
            tick();
        end
        q = s[8:1];
        r = s[0];
    endtask
endmodule

// File: verif/test_i2c_slave_ack_data_timeout.sv
`timescale 1ns/10ps
// Bench: register port master plus bus master model
module test_i2c_slave_ack_data_timeout;
    import i2cs_pkg::*;
    logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, v, d, q;
    logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_irq, m_scl, m_sda, ack;
    wire scl = ~(o_scl_oe | m_scl); // Pull-up wired-and
    wire sda = ~(o_sda_oe | m_sda);
    logic [6:0] own;
    int bad_count = 0, n_checks = 0, irq_n = 0, b, sel;
    // Short watchdog tick so a full timeout fits in a few hundred cycles
    localparam int TICKS = 8;
    // Timeout control after an overflow: enable cleared, flag set, period kept
    function automatic logic [7:0] toc_after(input int s);
        return {2'b01, 6'(s)};
    endfunction
    always #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_irq === 1'b1) irq_n++;
    i2cs_top #(.TICK_CYCLES(TICKS)) i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl), .i_sda(sda),
        .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
    i2c_master_model i_mst (.i_mclk(i_mclk), .i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));
    task automatic wr(input logic [2:0] a, input logic [7:0] w);
        @(posedge i_mclk);
        i_addr <= a; i_wdata <= w; i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge i_mclk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 r = o_rdata;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog, well above the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge i_mclk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(96715));
        own = 7'($urandom);
        repeat (16) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(ADR_TOC, v); chk(v, RST_TOC);
        rd(ADR_CTRL1, v); chk(v, RST_CTRL1);
        wr(ADR_OWN, {own, 1'b0}); wr(ADR_CTRL0, 8'h80);
        rd(ADR_OWN, v); chk(v, {own, 1'b0});
        // Wrong address: no acknowledge, master stops
        i_mst.start(); i_mst.xfer({own ^ 7'h40, 1'b0}, 1'b1, q, ack); chk({7'h0, ack}, 8'h01);
        i_mst.stop();
        // Master writes two random bytes
        i_mst.start(); i_mst.xfer({own, 1'b0}, 1'b1, q, ack); chk({7'h0, ack}, 8'h00);
        rd(ADR_CTRL1, v); chk(v & 8'h54, 8'h40);
        chk({7'h0, o_scl_oe}, 8'h01);
        chk({6'h0, o_scl_out, o_sda_out}, 8'h00);
        rd(ADR_DATA, v); repeat (2) @(posedge i_mclk); chk({7'h0, o_scl_oe}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            // Second byte is refused by software through the sent-ack bit
            wr(ADR_CTRL1, k[0] ? 8'h08 : 8'h00);
            i_mst.xfer(d, 1'b1, q, ack); chk({7'h0, ack}, {7'h0, k[0]});
            rd(ADR_DATA, v); chk(v, d);
        end
        i_mst.stop();
        // Master reads two bytes, acks the first only
        i_mst.start(); i_mst.xfer({own, 1'b1}, 1'b1, q, ack); chk({7'h0, ack}, 8'h00);
        rd(ADR_CTRL1, v); chk(v & 8'h54, 8'h54);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            wr(ADR_DATA, d);
            i_mst.xfer(8'hff, k[0], q, ack); chk(q, d);
        end
        rd(ADR_CTRL1, v); chk(v & 8'h01, 8'h01);
        chk({7'h0, o_sda_oe}, 8'h00);
        i_mst.stop();
        // Stalled transfer runs into the timeout
        // A master bit lasts about 31 cycles, so shorter periods expire mid-bit
        sel = 5 + $urandom % 59;
        wr(ADR_TOC, 8'h80 | 8'(sel));
        i_mst.start(); i_mst.xfer({own, 1'b0}, 1'b1, q, ack);
        b = irq_n;
        repeat ((sel + 2) * TICKS + 20) @(posedge i_mclk);
        rd(ADR_TOC, v); chk(v, toc_after(sel));
        rd(ADR_CTRL1, v); chk(v, RST_CTRL1);
        rd(ADR_OWN, v); chk(v, {own, 1'b0});
        chk({7'h0, o_scl_oe}, 8'h00);
        chk({7'h0, irq_n > b}, 8'h01);
        wr(ADR_TOC, 8'h00); rd(ADR_TOC, v); chk(v, 8'h00);
        i_mst.stop();
        report_and_stop();
    end
endmodule
